// [swrc_pkg.sv]
package swrc_pkg;
    localparam int          STOP_BIT   = 7;      // standby control stop request
    localparam int          SLEEP_BIT  = 6;      // sleep_request_bit position
    localparam logic [7:0]  WPR_KEY1   = 8'hA5;  // first postpone key
    localparam logic [7:0]  WPR_KEY2   = 8'h5A;  // second postpone key
    localparam int          RSRC_POR   = 7;      // power_on_reset_flag position
    localparam int          RSRC_WDT   = 5;      // watchdog reset flag position
    localparam int          RSRC_PIN   = 4;      // pin reset flag position
    localparam logic [7:0]  RSRC_RESET = 8'h80;  // flags after power-on
    localparam int          DMA_SUPPRESSION_REGISTER_W     = 4;      // dma suppression width
    localparam logic [1:0]  GEAR_1_1   = 2'h0;   // cpu gear code for 1/1
    localparam int          TB_WIDTH   = 20;     // default timebase width
    localparam int          WDT_TAP0   = 8;      // shortest tap below top
    localparam logic [1:0]  SYNC_RST   = 2'h1;   // synchroniser idle {nmi, pin_n}
    localparam logic [1:0]  PEND_NONE  = 2'h0;   // no standby request
    localparam logic [1:0]  PEND_SLEEP = 2'h1;   // sleep request held
    localparam logic [1:0]  PEND_STOP  = 2'h2;   // stop request held

    typedef enum logic [2:0]
    {
        ST_OSCW  = 3'h0,
        ST_RESET = 3'h1,
        ST_RUN   = 3'h3,
        ST_SLEEP = 3'h2,
        ST_STOP  = 3'h6
    } swrc_state_type;
endpackage

// [swrc_timebase.sv]
`timescale 1ns/10ps
`default_nettype none
module swrc_timebase
#(
    parameter int TB_W = 20
)
(
    input  wire logic            clk_sys,  // system clock
    input  wire logic            rst,      // async reset
    input  wire logic            run,      // oscillator running
    input  wire logic            clear,    // restart count
    input  wire logic            div2,     // clock_source_select
    output logic [TB_W-1:0]      tb_fall   // per-bit falling edge pulses
);
    logic [TB_W-1:0] cnt_ff;     // timebase count
    logic [TB_W-1:0] nxt_cnt;
    logic            div_ff;     // half-rate phase
    logic            nxt_div;
    logic            inc;        // count enable pulse
    logic [TB_W-1:0] fall_c;     // bits about to fall
    logic [TB_W-1:0] fall_ff;

    // bit i falls when all lower bits and itself are ones at an increment
    genvar i;
    generate
        for (i = 0; i < TB_W; i++)
        begin : g_fall
            assign fall_c[i] = inc & (&cnt_ff[i:0]) & ~clear;
        end
    endgenerate

    // divide by two selects twice the oscillator period
    always_comb
    begin
        nxt_div = run ? ~div_ff : div_ff;
        inc     = run & (~div2 | div_ff);
        nxt_cnt = cnt_ff;
        if (clear)
            nxt_cnt = '0;
        else if (inc)
            nxt_cnt = cnt_ff + 1'b1;
    end

    // state registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff  <= '0;
            div_ff  <= 1'b0;
            fall_ff <= '0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            div_ff  <= nxt_div;
            fall_ff <= fall_c;
        end
    end

    assign tb_fall = fall_ff;
endmodule
`default_nettype wire

// [swrc_watchdog.sv]
`timescale 1ns/10ps
`default_nettype none
module swrc_watchdog
(
    input  wire logic        clk_sys,    // system clock
    input  wire logic        rst,        // async reset
    input  wire logic        clear,      // internal reset, stops watchdog
    input  wire logic        ctrl_wr,    // watchdog_control_register write
    input  wire logic [1:0]  ctrl_sel,   // {hi, lo} interval select
    input  wire logic        post_wr,    // watchdog_postpone_register write
    input  wire logic [7:0]  post_data,  // postpone write data
    input  wire logic [3:0]  tap_fall,   // falls of the four taps
    output logic             running,    // watchdog started
    output logic             fire        // one-cycle reset request
);
    logic       run_ff;    // started
    logic       nxt_run;
    logic [1:0] sel_ff;    // latched interval
    logic [1:0] nxt_sel;
    logic       key_ff;    // first key seen
    logic       nxt_key;
    logic       wd_ff;     // watchdog reset flop
    logic       nxt_wd;
    logic       fire_ff;
    logic       nxt_fire;
    logic       tick;      // selected tap fell

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // start, key sequence and reset flop
    always_comb
    begin
        tick     = tap_fall[sel_ff] & run_ff;
        nxt_run  = run_ff;
        nxt_sel  = sel_ff;
        nxt_key  = key_ff;
        nxt_wd   = wd_ff;
        nxt_fire = 1'b0;
        if (ctrl_wr & ~run_ff)
        begin
            nxt_run = 1'b1;
            nxt_sel = ctrl_sel;  // later writes ignored
        end
        if (post_wr)
        begin
            // no timer between keys, only the flop bounds the interval
            if (post_data == swrc_pkg::WPR_KEY1)
                nxt_key = 1'b1;
            else if (post_data == swrc_pkg::WPR_KEY2 && key_ff)
            begin
                nxt_key = 1'b0;
                nxt_wd  = 1'b0;
            end
            else
                nxt_key = 1'b0;  // stray value drops the first key
        end
        // tap fall sets the flop, set wins over a postpone
        if (tick)
        begin
            nxt_wd   = 1'b1;
            nxt_fire = wd_ff;
        end
        if (clear)
        begin
            nxt_run  = 1'b0;
            nxt_sel  = 2'h0;
            nxt_key  = 1'b0;
            nxt_wd   = 1'b0;
            nxt_fire = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            run_ff  <= 1'b0;
            sel_ff  <= 2'h0;
            key_ff  <= 1'b0;
            wd_ff   <= 1'b0;
            fire_ff <= 1'b0;
        end
        else
        begin
            run_ff  <= nxt_run;
            sel_ff  <= nxt_sel;
            key_ff  <= nxt_key;
            wd_ff   <= nxt_wd;
            fire_ff <= nxt_fire;
        end
    end

    assign running = run_ff;
    assign fire    = fire_ff;

    chk_interval_lock: assert property (run_ff && ctrl_wr && !clear |=> $stable(sel_ff))
        else $error("interval changed after start");
    chk_wdt_fire: assert property (tick && wd_ff && !clear |=> fire_ff)
        else $error("second tap fall did not reset");
    chk_key_drop: assert property (post_wr && post_data != swrc_pkg::WPR_KEY1 && !clear |=> !key_ff)
        else $error("stale first key kept");
endmodule
`default_nettype wire

// [swrc_top.sv]
`timescale 1ns/10ps
`default_nettype none
module swrc_top
#(
    parameter int TB_W = swrc_pkg::TB_WIDTH  // timebase width, shrink for sim
)
(
    input  wire logic        clk_sys,              // system clock
    input  wire logic        rst,                  // async power-on reset
    input  wire logic        reset_pin_n,          // external reset pin
    input  wire logic        nmi_pin,              // non-maskable interrupt pin
    input  wire logic        irq_pending,          // any peripheral request
    input  wire logic        irq_is_dma,           // request routed to dma
    input  wire logic        higher_irq,           // higher interrupt during dma
    input  wire logic        dma_req,              // dma transfer request
    input  wire logic        cbus_busy,            // internal bus access
    input  wire logic        standby_control_register_wr,              // standby_control_register write
    input  wire logic [7:0]  standby_control_register_wdata,           // standby write data
    input  wire logic        watchdog_control_register_wr,              // watchdog_control_register write
    input  wire logic [1:0]  watchdog_control_register_wdata,           // interval select hi, lo
    input  wire logic        wpr_wr,               // postpone register write
    input  wire logic [7:0]  wpr_wdata,            // postpone data
    input  wire logic        rsrc_rd,              // reset_source_register read
    input  wire logic        dma_suppression_register_wr,              // dma_suppression_register write
    input  wire logic [3:0]  dma_suppression_register_wdata,           // suppression data
    input  wire logic        clock_source_select,  // 1 divide-by-two, 0 pll
    input  wire logic        bus_doubler_enable,   // doubler request
    input  wire logic [1:0]  cpu_gear_field,       // programmed cpu gear
    output logic [7:0]       reset_source,         // reset source flags
    output logic [3:0]       dma_suppress,         // suppression count
    output logic             int_reset,            // internal reset
    output logic             cpu_clk_en,           // cpu clock running
    output logic             bus_clk_en,           // internal bus clock running
    output logic             periph_clk_en,        // dma, peripheral clocks
    output logic             dma_grant,            // dma may transfer
    output logic             bus_doubler_ack,      // doubler switched
    output logic [1:0]       cpu_gear_eff,         // gear in force
    output logic             sleeping,             // sleep state
    output logic             stopped               // stop state
);
    swrc_pkg::swrc_state_type state_ff;   // standby state
    swrc_pkg::swrc_state_type nxt_state;
    logic [1:0] pend_ff;                  // held standby request
    logic [1:0] nxt_pend;
    logic       to_run_ff;                // oscillator wait ends in run
    logic       nxt_to_run;
    logic       por_ff;                   // first wait after power-on
    logic       nxt_por;
    logic [1:0] sync1_ff;                 // {nmi, pin_n} first stage
    logic [1:0] sync2_ff;                 // second stage
    logic [7:0] rsrc_ff;                  // reset source flags
    logic [7:0] nxt_rsrc;
    logic [3:0] dma_suppression_register_ff;                  // suppression count
    logic [3:0] nxt_dma_suppression_register;
    logic       grant_ff;
    logic       nxt_grant;
    logic       dbl_ff;                   // doubler in force
    logic       nxt_dbl;
    logic       dead_ff;                  // dead clock cycle
    logic       nxt_dead;
    logic [1:0] gear_ff;
    logic [1:0] nxt_gear;
    logic       irst_ff;
    logic       nxt_irst;
    logic       cpu_ff;
    logic       nxt_cpu;
    logic       bus_ff;
    logic       nxt_bus;
    logic       per_ff;
    logic       nxt_per;
    logic       pin_rst;                  // synchronised reset pin
    logic       nmi_s;                    // synchronised nmi
    logic       wake;                     // wake-up cause
    logic       wdt_fire;                 // watchdog reset request
    logic       tb_clear;                 // restart timebase
    logic [TB_W-1:0] tb_fall;             // timebase falls
    logic [3:0] wdt_taps;                 // watchdog interval taps
    logic       osc_done;                 // oscillator wait over

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    assign pin_rst  = ~sync2_ff[0];
    assign nmi_s    = sync2_ff[1];
    assign osc_done = tb_fall[TB_W-1];    // top bit times the wait
    assign tb_clear = (state_ff != swrc_pkg::ST_OSCW) && (nxt_state == swrc_pkg::ST_OSCW);

    // longer select means a higher tap
    genvar t;
    generate
        for (t = 0; t < 4; t++)
        begin : g_tap
            assign wdt_taps[t] = tb_fall[TB_W-swrc_pkg::WDT_TAP0+2*t];
        end
    endgenerate

    // timebase stops with the oscillator in the stop state
    swrc_timebase #(.TB_W(TB_W)) u_tb
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (state_ff != swrc_pkg::ST_STOP),
        .clear   (tb_clear),
        .div2    (clock_source_select),
        .tb_fall (tb_fall)
    );

    swrc_watchdog u_wdt
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clear     (irst_ff),
        .ctrl_wr   (watchdog_control_register_wr),
        .ctrl_sel  (watchdog_control_register_wdata),
        .post_wr   (wpr_wr),
        .post_data (wpr_wdata),
        .tap_fall  (wdt_taps),
        .running   (),
        .fire      (wdt_fire)
    );

    // standby state machine
    always_comb
    begin
        wake       = (irq_pending & ~irq_is_dma) | nmi_s;
        nxt_state  = state_ff;
        nxt_pend   = pend_ff;
        nxt_to_run = to_run_ff;
        case (state_ff)
            swrc_pkg::ST_OSCW:
            begin
                // wait over: reset state, or run after a stop wake
                if (osc_done)
                    nxt_state = to_run_ff ? swrc_pkg::ST_RUN : swrc_pkg::ST_RESET;
            end
            swrc_pkg::ST_RESET:
            begin
                if (!pin_rst)
                    nxt_state = swrc_pkg::ST_RUN;
            end
            swrc_pkg::ST_RUN:
            begin
                // write with a request outstanding is ignored
                if (standby_control_register_wr && !irq_pending)
                begin
                    if (standby_control_register_wdata[swrc_pkg::STOP_BIT])
                        nxt_pend = swrc_pkg::PEND_STOP;
                    else if (standby_control_register_wdata[swrc_pkg::SLEEP_BIT])
                        nxt_pend = swrc_pkg::PEND_SLEEP;
                end
                if (irq_pending)
                    nxt_pend = swrc_pkg::PEND_NONE;
                // dma and bus traffic finish before clocks stop
                if (pend_ff != swrc_pkg::PEND_NONE && !dma_req && !cbus_busy
                    && !irq_pending)
                begin
                    nxt_state = pend_ff[1] ? swrc_pkg::ST_STOP : swrc_pkg::ST_SLEEP;
                    nxt_pend  = swrc_pkg::PEND_NONE;
                end
            end
            swrc_pkg::ST_SLEEP:
            begin
                if (wake)
                    nxt_state = swrc_pkg::ST_RUN;
            end
            swrc_pkg::ST_STOP:
            begin
                // oscillator must settle before clocks return
                if (wake)
                begin
                    nxt_state  = swrc_pkg::ST_OSCW;
                    nxt_to_run = 1'b1;
                end
            end
            default:
            begin
                nxt_state = swrc_pkg::ST_OSCW;
            end
        endcase
        // reset causes override the standby state, except during the oscillator wait
        if (pin_rst || wdt_fire)
        begin
            nxt_pend   = swrc_pkg::PEND_NONE;
            nxt_to_run = 1'b0;
            if (state_ff == swrc_pkg::ST_STOP)
                nxt_state = swrc_pkg::ST_OSCW;
            else if (state_ff != swrc_pkg::ST_OSCW)
                nxt_state = swrc_pkg::ST_RESET;
        end
        nxt_por = por_ff & (nxt_state == swrc_pkg::ST_OSCW);
    end

    // clock enables: bus restarts in reset state, cpu only in run
    always_comb
    begin
        nxt_irst = (nxt_state == swrc_pkg::ST_RESET)
                 | ((nxt_state == swrc_pkg::ST_OSCW) & ~nxt_to_run);
        nxt_bus  = (nxt_state == swrc_pkg::ST_RUN) | (nxt_state == swrc_pkg::ST_RESET);
        nxt_cpu  = (nxt_state == swrc_pkg::ST_RUN) & ~nxt_dead;
        // only the power-on wait supplies clocks for initialisation
        nxt_per  = (nxt_state != swrc_pkg::ST_STOP)
                 & ~((nxt_state == swrc_pkg::ST_OSCW) & ~nxt_por);
    end

    // reset source flags, a set beats a clearing read
    always_comb
    begin
        nxt_rsrc = rsrc_rd ? 8'h00 : rsrc_ff;
        if (wdt_fire)
            nxt_rsrc[swrc_pkg::RSRC_WDT] = 1'b1;
        if (pin_rst)
            nxt_rsrc[swrc_pkg::RSRC_PIN] = 1'b1;
    end

    // dma suppression and pause
    always_comb
    begin
        nxt_dma_suppression_register  = dma_suppression_register_wr ? dma_suppression_register_wdata : dma_suppression_register_ff;  // four bits, 15 nests
        nxt_grant = dma_req & ~higher_irq
                  & (dma_suppression_register_ff == 4'h0)
                  & ((state_ff == swrc_pkg::ST_RUN) | (state_ff == swrc_pkg::ST_SLEEP));
    end

    // doubler switches only with the internal bus idle
    always_comb
    begin
        nxt_dbl  = dbl_ff;
        nxt_dead = 1'b0;
        if (bus_doubler_enable != dbl_ff && !cbus_busy)
        begin
            nxt_dbl  = bus_doubler_enable;
            nxt_dead = 1'b1;  // one lost clock, timers may see it
        end
        nxt_gear = nxt_dbl ? swrc_pkg::GEAR_1_1 : cpu_gear_field;
    end

    // pin synchronisers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync1_ff <= swrc_pkg::SYNC_RST;
            sync2_ff <= swrc_pkg::SYNC_RST;
        end
        else
        begin
            sync1_ff <= {nmi_pin, reset_pin_n};
            sync2_ff <= sync1_ff;
        end
    end

    // state registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_ff  <= swrc_pkg::ST_OSCW;
            pend_ff   <= swrc_pkg::PEND_NONE;
            to_run_ff <= 1'b0;
            por_ff    <= 1'b1;
            rsrc_ff   <= swrc_pkg::RSRC_RESET;
            dma_suppression_register_ff   <= 4'h0;
            grant_ff  <= 1'b0;
            dbl_ff    <= 1'b0;
            dead_ff   <= 1'b0;
            gear_ff   <= swrc_pkg::GEAR_1_1;
            irst_ff   <= 1'b1;
            cpu_ff    <= 1'b0;
            bus_ff    <= 1'b0;
            per_ff    <= 1'b1;
        end
        else
        begin
            state_ff  <= nxt_state;
            pend_ff   <= nxt_pend;
            to_run_ff <= nxt_to_run;
            por_ff    <= nxt_por;
            rsrc_ff   <= nxt_rsrc;
            dma_suppression_register_ff   <= nxt_dma_suppression_register;
            grant_ff  <= nxt_grant;
            dbl_ff    <= nxt_dbl;
            dead_ff   <= nxt_dead;
            gear_ff   <= nxt_gear;
            irst_ff   <= nxt_irst;
            cpu_ff    <= nxt_cpu;
            bus_ff    <= nxt_bus;
            per_ff    <= nxt_per;
        end
    end

    assign reset_source    = rsrc_ff;
    assign dma_suppress    = dma_suppression_register_ff;
    assign int_reset       = irst_ff;
    assign cpu_clk_en      = cpu_ff;
    assign bus_clk_en      = bus_ff;
    assign periph_clk_en   = per_ff;
    assign dma_grant       = grant_ff;
    assign bus_doubler_ack = dbl_ff;
    assign cpu_gear_eff    = gear_ff;
    assign sleeping        = (state_ff == swrc_pkg::ST_SLEEP);
    assign stopped         = (state_ff == swrc_pkg::ST_STOP);

    chk_sleep_ignored: assert property (state_ff == swrc_pkg::ST_RUN && standby_control_register_wr && irq_pending
        && pend_ff == swrc_pkg::PEND_NONE |=> pend_ff == swrc_pkg::PEND_NONE)
        else $error("standby write taken with interrupt pending");
    chk_dma_first: assert property (state_ff == swrc_pkg::ST_RUN && dma_req
        |=> state_ff != swrc_pkg::ST_SLEEP)
        else $error("sleep entered over a dma request");
    chk_dma_nowake: assert property (state_ff == swrc_pkg::ST_SLEEP && !wake && !pin_rst
        && !wdt_fire |=> state_ff == swrc_pkg::ST_SLEEP)
        else $error("sleep left without a wake cause");
    chk_stop_wake: assert property (state_ff == swrc_pkg::ST_STOP && wake && !pin_rst
        && !wdt_fire |=> state_ff == swrc_pkg::ST_OSCW && to_run_ff && !irst_ff)
        else $error("stop wake skipped oscillator wait");
    chk_sleep_reset: assert property (state_ff == swrc_pkg::ST_SLEEP && pin_rst
        |=> state_ff == swrc_pkg::ST_RESET && irst_ff && bus_ff && !cpu_ff)
        else $error("sleep reset order wrong");
    chk_flag_sticky: assert property (rsrc_ff[swrc_pkg::RSRC_WDT] && !rsrc_rd
        |=> rsrc_ff[swrc_pkg::RSRC_WDT])
        else $error("source flag lost without read");
    chk_read_clear: assert property (rsrc_rd && !wdt_fire && !pin_rst |=> rsrc_ff == 8'h00)
        else $error("read did not clear flags");
    chk_dma_block: assert property (dma_suppression_register_ff != 4'h0 || higher_irq |=> !grant_ff)
        else $error("dma granted while suppressed");
    chk_gear_forced: assert property (dbl_ff |-> gear_ff == swrc_pkg::GEAR_1_1)
        else $error("gear not 1/1 with doubler");
    chk_dbl_wait: assert property (cbus_busy |=> $stable(dbl_ff))
        else $error("doubler switched during bus access");
    chk_wdt_reset: assert property (wdt_fire |=> irst_ff && rsrc_ff[swrc_pkg::RSRC_WDT])
        else $error("watchdog reset not applied");
endmodule
`default_nettype wire

// [standby_watchdog_reset_ctrl_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module standby_watchdog_reset_ctrl_bench;
    logic clk_sys, rst, reset_pin_n, nmi_pin, irq_pending, irq_is_dma, higher_irq;
    logic dma_req, cbus_busy, standby_control_register_wr, watchdog_control_register_wr, wpr_wr, rsrc_rd, dma_suppression_register_wr;
    logic clock_source_select, bus_doubler_enable, int_reset, cpu_clk_en, bus_clk_en;
    logic periph_clk_en, dma_grant, bus_doubler_ack, sleeping, stopped, seen;
    logic [7:0] standby_control_register_wdata, wpr_wdata, reset_source;
    logic [1:0] watchdog_control_register_wdata, cpu_gear_field, cpu_gear_eff;
    logic [3:0] dma_suppression_register_wdata, dma_suppress;
    int         err_total = 0;  // mismatches
    int         tests_run = 0;  // comparisons
    // short timebase keeps every oscillator wait near a thousand cycles
    swrc_top #(.TB_W(10)) DUT (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // latches any internal reset pulse, which may be too short to poll
    always @(posedge clk_sys) if (int_reset === 1'b1) seen <= 1'b1;
    task tick(input int n); repeat (n) @(posedge clk_sys); #1; endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // each write holds its strobe one edge, then one idle edge
    task standby_control_register(input logic [7:0] v); standby_control_register_wdata = v; standby_control_register_wr = 1; tick(1); standby_control_register_wr = 0; tick(1); endtask
    task watchdog_postpone_register(input logic [7:0] v); wpr_wdata = v; wpr_wr = 1; tick(1); wpr_wr = 0; tick(1); endtask
    task dma_suppression_register(input logic [3:0] v); dma_suppression_register_wdata = v; dma_suppression_register_wr = 1; tick(1); dma_suppression_register_wr = 0; tick(1); endtask
    task wait_run;
        for (int k = 0; k < 3000 && cpu_clk_en !== 1'b1; k++) tick(1);
        chk(cpu_clk_en, 8'h01);
    endtask
    task t_flags;
        chk(reset_source, 8'h80);
        rsrc_rd = 1; tick(1); rsrc_rd = 0; tick(1);
        chk(reset_source, 8'h00);
    endtask
    task t_sleep;
        standby_control_register(8'h40); tick(2);
        chk(sleeping, 8'h01);
        irq_pending = 1; irq_is_dma = 1; tick(4);
        chk(sleeping, 8'h01);
        irq_is_dma = 0; tick(3);
        chk(sleeping, 8'h00);
        standby_control_register(8'h40); tick(2);
        chk(sleeping, 8'h00);
        irq_pending = 0; standby_control_register(8'h80); tick(2);
        chk(stopped, 8'h01);
        nmi_pin = 1; tick(6); nmi_pin = 0;
        chk(stopped, 8'h00);
        wait_run;
    endtask
    task t_dma;
        dma_req = 1; dma_suppression_register(4'h1); tick(2);
        chk(dma_grant, 8'h00);
        dma_suppression_register(4'hF); chk(dma_suppress, 8'h0F);
        dma_suppression_register(4'h0); tick(2);
        chk(dma_grant, 8'h01);
        higher_irq = 1; tick(2);
        chk(dma_grant, 8'h00);
        higher_irq = 0; tick(2);
        chk(dma_grant, 8'h01);
        standby_control_register(8'h40); tick(2);
        chk(sleeping, 8'h00);
        dma_req = 0; tick(3);
        chk(sleeping, 8'h01);
        nmi_pin = 1; tick(5); nmi_pin = 0;
        chk(sleeping, 8'h00);
    endtask
    task t_dbl;
        cpu_gear_field = 2'h3; cbus_busy = 1; bus_doubler_enable = 1; tick(3);
        chk(bus_doubler_ack, 8'h00);
        cbus_busy = 0; tick(2);
        chk(bus_doubler_ack, 8'h01);
        chk(cpu_gear_eff, 8'h00);
        bus_doubler_enable = 0; tick(2);
        chk(cpu_gear_eff, 8'h03);
    endtask
    // pin reset while asleep, then a power-on reset in mid-run
    task t_pin;
        standby_control_register(8'h40); tick(2);
        chk(sleeping, 8'h01);
        reset_pin_n = 0; tick(4);
        chk(int_reset, 8'h01);
        chk(bus_clk_en, 8'h01);
        chk(cpu_clk_en, 8'h00);
        reset_pin_n = 1; tick(4);
        chk(cpu_clk_en, 8'h01);
        chk(reset_source[4], 8'h01);
        rst = 1; tick(2); rst = 0; tick(1);
        chk(reset_source, 8'h80);
        wait_run;
    endtask
    task t_wdt;
        watchdog_control_register_wdata = 2'h0; watchdog_control_register_wr = 1; tick(1); watchdog_control_register_wr = 0; tick(1); seen = 0;
        repeat (20)
        begin
            watchdog_postpone_register(8'hA5); watchdog_postpone_register(8'h5A);
        end
        chk(seen, 8'h00);
        // a stray value between the keys drops the first key
        repeat (20)
        begin
            watchdog_postpone_register(8'hA5); watchdog_postpone_register(8'h11); watchdog_postpone_register(8'h5A);
        end
        chk(seen, 8'h01);
        wait_run;
        chk(reset_source[5], 8'h01);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        {nmi_pin, irq_pending, irq_is_dma, higher_irq, dma_req, cbus_busy} = '0;
        {standby_control_register_wr, watchdog_control_register_wr, wpr_wr, rsrc_rd, dma_suppression_register_wr, clock_source_select} = '0;
        {standby_control_register_wdata, wpr_wdata, watchdog_control_register_wdata, dma_suppression_register_wdata, cpu_gear_field} = '0;
        bus_doubler_enable = 0; seen = 0; rst = 1; reset_pin_n = 1;
        tick(12); rst = 0;
        wait_run; t_flags; t_sleep; t_dma; t_dbl; t_pin; t_wdt;
        report_and_stop;
    end
    // hang guard well past the expected run length
    initial
    begin
        #200000;
        err_total++;
        report_and_stop;
    end
endmodule
`default_nettype wire
